//--- sdc_decoder.sv
/*
 * Command-pin decoder and data-pin logic of a 16-bit synchronous DRAM, with a
 * small backing store and a write buffer in front of it.
 * Assumes pins driven by an external controller, sampled on rising CLOCK edges.
 */
// Overview of operation
// - command decoder works only with select low
// - select high forces deselect, strobes ignored
// - strobes captured on rising clock edges while CE is high
// - open command activates the selected bank
// - close command idles bank after precharge
// - column access: write or read by write_select
// - byte masks gate read drivers, block writes
// - data lines clocked, maskable per byte
// - row on open, column and auto-close on access
// - close with auto_close_bit precharges all banks
`timescale 1ns/100ps
module sdc_decoder
	import sdc_pkg::*;
#(
	parameter int PRE_COUNT = sdc_pkg::PRE_CYCLES,
	parameter int WBUF_DEPTH = sdc_pkg::FIFO_DEPTH
) (
	input wire logic CLOCK, // system clock
	input wire logic RST, // synchronous reset, active high
	input wire logic CE, // clock enable, freezes all state when low
	input wire logic CS_N, // chip select, active low
	input wire logic ROW_STROBE_N, // row strobe, active low
	input wire logic COL_STROBE_N, // column strobe, active low
	input wire logic WRITE_SELECT_N, // write select, active low
	input wire logic [sdc_pkg::BANK_W-1:0] BANK_SELECT, // bank address
	input wire logic [sdc_pkg::ROW_W-1:0] ADDR, // row / column address
	input wire logic LOWER_BYTE_MASK, // mask for bits 7:0
	input wire logic UPPER_BYTE_MASK, // mask for bits 15:8
	input wire logic [sdc_pkg::DATA_W-1:0] DATA_LINES_IN, // data pins, input side
	output logic [sdc_pkg::DATA_W-1:0] DATA_LINES_OUT, // data pins, output side
	output logic [sdc_pkg::MASK_W-1:0] DATA_LINES_OE, // per-byte drive enable
	output logic [sdc_pkg::NUM_BANKS-1:0] BANK_ACTIVE, // banks in active state
	output logic WR_READY // write buffer has room
);
	import sdc_pkg::*;

	if (PRE_COUNT < 1 || PRE_COUNT > (1 << PRE_CNT_W) || WBUF_DEPTH < 2) begin : g_bad_param
		$error("sdc_decoder parameter out of range");
	end

	localparam logic [PRE_CNT_W-1:0] PRE_LAST = PRE_CNT_W'(PRE_COUNT - 1);
	localparam int WR_W = $bits(sdc_wr_t);
	localparam int MEM_WORDS = NUM_BANKS << MEM_COL_W;

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	sdc_pins_t pins_in;
	sdc_pins_t pins_meta;
	sdc_pins_t s;

	assign pins_in = '{cs_n: CS_N, ras_n: ROW_STROBE_N, cas_n: COL_STROBE_N,
		we_n: WRITE_SELECT_N, ba: BANK_SELECT, addr: ADDR, lower_byte_mask: LOWER_BYTE_MASK,
		upper_byte_mask: UPPER_BYTE_MASK, dq: DATA_LINES_IN};

	// all pins, data included, take the same two stages so they stay aligned
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pins_meta <= '1;
			s <= '1;
		end else if (CE) begin
			pins_meta <= pins_in;
			s <= pins_meta;
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	sdc_cmd_t cmd;
	sdc_bank_t bank_st [NUM_BANKS];
	sdc_bank_t next_st [NUM_BANKS];
	logic [PRE_CNT_W-1:0] pre_cnt [NUM_BANKS];
	logic [ROW_W-1:0] open_row [NUM_BANKS];
	logic [NUM_BANKS-1:0] open_hit;
	logic [NUM_BANKS-1:0] close_hit;
	logic [NUM_BANKS-1:0] auto_hit;
	logic [NUM_BANKS-1:0] next_active;
	logic [NUM_BANKS-1:0] busy_pre;

	assign cmd = sdc_decode(s.cs_n, s.ras_n, s.cas_n, s.we_n);

	wire auto_close = s.addr[AUTO_BIT];
	wire is_access = (cmd == CMD_READ) || (cmd == CMD_WRITE);
	wire sel_active = (bank_st[s.ba] == BK_ACTIVE);
	wire rd_hit = (cmd == CMD_READ) && sel_active;
	wire wr_hit = (cmd == CMD_WRITE) && sel_active;
	wire [MASK_W-1:0] mask = {s.upper_byte_mask, s.lower_byte_mask};
	wire [MEM_COL_W-1:0] col = s.addr[MEM_COL_W-1:0];

	// ----------------------------------------------------------------
	// bank state machines
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
		wire sel = (s.ba == BANK_W'(i));

		assign open_hit[i] = (cmd == CMD_OPEN) && sel;
		assign close_hit[i] = (cmd == CMD_CLOSE) && (auto_close || sel);
		assign auto_hit[i] = is_access && auto_close && sel;
		assign next_active[i] = (next_st[i] == BK_ACTIVE);
		assign busy_pre[i] = (bank_st[i] == BK_PRECHARGE);

		always_comb begin
			next_st[i] = bank_st[i];
			unique case (bank_st[i])
				BK_IDLE: if (open_hit[i]) next_st[i] = BK_ACTIVE;
				BK_ACTIVE: if (close_hit[i] || auto_hit[i]) next_st[i] = BK_PRECHARGE;
				BK_PRECHARGE: if (pre_cnt[i] == '0) next_st[i] = BK_IDLE;
				default: next_st[i] = BK_IDLE;
			endcase
		end

		always_ff @(posedge CLOCK) begin
			if (RST) begin
				bank_st[i] <= BK_IDLE;
				pre_cnt[i] <= '0;
				open_row[i] <= '0;
			end else if (CE) begin
				bank_st[i] <= next_st[i];
				if (bank_st[i] != BK_PRECHARGE) pre_cnt[i] <= PRE_LAST;
				else pre_cnt[i] <= pre_cnt[i] - 1'b1;
				if (bank_st[i] == BK_IDLE && open_hit[i]) open_row[i] <= s.addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// write buffer and store
	// ----------------------------------------------------------------
	sdc_fifo_if #(.W(WR_W)) wbuf ();
	sdc_wr_t wr_entry;
	sdc_wr_t drain;
	logic [DATA_W-1:0] mem [MEM_WORDS];

	assign wr_entry = '{mask: mask, bank: s.ba, col: col, data: s.dq};
	assign wbuf.in_valid = wr_hit;
	assign wbuf.in_data = wr_entry;
	// the store has one port; a read takes it and the buffer waits
	assign wbuf.out_ready = !rd_hit;
	assign drain = wbuf.out_data;

	wire do_drain = wbuf.out_valid && wbuf.out_ready;
	wire [BANK_W+MEM_COL_W-1:0] rd_idx = {s.ba, col};
	wire [BANK_W+MEM_COL_W-1:0] wr_idx = {drain.bank, drain.col};

	sdc_fifo #(
		.WIDTH(WR_W),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.port(wbuf)
	);

	// masked bytes never reach the store
	always_ff @(posedge CLOCK) begin
		if (CE && do_drain) begin
			for (int b = 0; b < MASK_W; b++) begin
				if (!drain.mask[b]) mem[wr_idx][b*BYTE_W +: BYTE_W] <= drain.data[b*BYTE_W +: BYTE_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	// a read issued while its address still waits in the buffer returns the old word
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			DATA_LINES_OUT <= '0;
			DATA_LINES_OE <= '0;
			BANK_ACTIVE <= '0;
			WR_READY <= 1'b0;
		end else if (CE) begin
			DATA_LINES_OUT <= rd_hit ? mem[rd_idx] : '0;
			DATA_LINES_OE <= rd_hit ? ~mask : '0;
			BANK_ACTIVE <= next_active;
			WR_READY <= wbuf.in_ready;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST || !CE);

	localparam int PRE_MAX = 16;

	property p_desel_quiet;
		cmd == CMD_DESEL |=> DATA_LINES_OE == '0 && $stable(BANK_ACTIVE);
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("deselect changed state");

	property p_sync_delay;
		$past(CE) && $past(CE, 2) && !$past(RST) && !$past(RST, 2) |-> s == $past(pins_in, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("pin capture misaligned");

	property p_cs_bit;
		s.cs_n |-> cmd == CMD_DESEL && !wbuf.in_valid;
	endproperty
	a_cs_bit: assert property (p_cs_bit) else $error("select high decoded a command");

	property p_open;
		cmd == CMD_OPEN && bank_st[s.ba] == BK_IDLE |=>
			BANK_ACTIVE[$past(s.ba)] && open_row[$past(s.ba)] == $past(s.addr);
	endproperty
	a_open: assert property (p_open) else $error("open did not activate bank");

	property p_close_one;
		cmd == CMD_CLOSE && !auto_close && sel_active |=>
			!BANK_ACTIVE[$past(s.ba)] ##0 (bank_st[$past(s.ba)] == BK_PRECHARGE);
	endproperty
	a_close_one: assert property (p_close_one) else $error("close missed bank");

	property p_pre_done;
		$rose(busy_pre[0]) |-> busy_pre[0] [*1] ##[0:PRE_MAX] bank_st[0] == BK_IDLE;
	endproperty
	a_pre_done: assert property (p_pre_done) else $error("precharge never ends");

	property p_close_all;
		cmd == CMD_CLOSE && auto_close |=> BANK_ACTIVE == '0;
	endproperty
	a_close_all: assert property (p_close_all) else $error("close all left a bank open");

	property p_read_oe;
		rd_hit |=> DATA_LINES_OE == ~$past(mask) ##1 1'b1;
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("read drive enable wrong");

	property p_write_push;
		wr_hit && wbuf.in_ready |=> wbuf.out_valid;
	endproperty
	a_write_push: assert property (p_write_push) else $error("write not buffered");

	property p_auto;
		is_access && auto_close && sel_active |=> bank_st[$past(s.ba)] == BK_PRECHARGE;
	endproperty
	a_auto: assert property (p_auto) else $error("auto close ignored");

	property p_nop;
		cmd == CMD_NOP && busy_pre == '0 |=> $stable(BANK_ACTIVE) && DATA_LINES_OE == '0;
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state");

	property p_other;
		cmd == CMD_OTHER && busy_pre == '0 |=> $stable(BANK_ACTIVE) && DATA_LINES_OE == '0;
	endproperty
	a_other: assert property (p_other) else $error("unsupported command changed state");

	// a low enable must leave every output exactly as it was
	property p_freeze;
		@(posedge CLOCK) disable iff (RST) !CE |=> $stable(BANK_ACTIVE) && $stable(WR_READY)
			&& $stable(DATA_LINES_OE) && $stable(DATA_LINES_OUT);
	endproperty
	a_freeze: assert property (p_freeze) else $error("clock enable low changed an output");

	property p_idle_access;
		is_access && !sel_active |-> !wbuf.in_valid ##1 DATA_LINES_OE == '0;
	endproperty
	a_idle_access: assert property (p_idle_access) else $error("access to closed bank acted");

	property p_out_quiet;
		!rd_hit |=> DATA_LINES_OE == '0 && DATA_LINES_OUT == '0;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("data lines driven without a read");

	// only unmasked lanes are checked; a masked lane may never have been written
	property p_store_lo;
		do_drain && !drain.mask[0] |=>
			mem[$past(wr_idx)][BYTE_W-1:0] == $past(drain.data[BYTE_W-1:0]);
	endproperty
	a_store_lo: assert property (p_store_lo) else $error("low byte not stored");

	property p_store_hi;
		do_drain && !drain.mask[1] |=>
			mem[$past(wr_idx)][DATA_W-1:BYTE_W] == $past(drain.data[DATA_W-1:BYTE_W]);
	endproperty
	a_store_hi: assert property (p_store_hi) else $error("high byte not stored");

	property p_open_busy;
		cmd == CMD_OPEN && bank_st[s.ba] != BK_IDLE |=>
			open_row[$past(s.ba)] == $past(open_row[s.ba]);
	endproperty
	a_open_busy: assert property (p_open_busy) else $error("open replaced a live row");

	property p_close_all_pre;
		cmd == CMD_CLOSE && auto_close && bank_st[0] == BK_ACTIVE |=> bank_st[0] == BK_PRECHARGE;
	endproperty
	a_close_all_pre: assert property (p_close_all_pre) else $error("close all skipped bank 0");

	c_open_read: cover property (cmd == CMD_OPEN ##[1:20] rd_hit);
	c_write_full: cover property (!wbuf.in_ready);
	c_close_all: cover property (cmd == CMD_CLOSE && auto_close && BANK_ACTIVE != '0);
	c_auto_write: cover property (wr_hit && auto_close);
	c_auto_read: cover property (rd_hit && auto_close);
endmodule // sdc_decoder

//--- sdc_pkg.sv
/*
 * Shared constants, pin bundle, command and bank-state types for the command-pin decoder.
 * Assumes a single 100 MHz clock domain and one external controller on the pins.
 */
package sdc_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int MASK_W = 2;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	// storage keeps only the low column bits of each bank, to stay small
	localparam int MEM_COL_W = 4;
	// position of the auto_close_bit within the address pins
	localparam int AUTO_BIT = 10;

	// ----------------------------------------------------------------
	// timing and buffering
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRECHARGE_NS = 20;
	localparam int PRE_CYCLES = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_CNT_W = 4;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_DESEL = 3'b000,
		CMD_NOP = 3'b001,
		CMD_OPEN = 3'b010,
		CMD_CLOSE = 3'b011,
		CMD_READ = 3'b100,
		CMD_WRITE = 3'b101,
		CMD_OTHER = 3'b110
	} sdc_cmd_t;

	typedef enum logic [1:0] {
		BK_IDLE = 2'b00,
		BK_ACTIVE = 2'b01,
		BK_PRECHARGE = 2'b10
	} sdc_bank_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] ba;
		logic [ROW_W-1:0] addr;
		logic lower_byte_mask;
		logic upper_byte_mask;
		logic [DATA_W-1:0] dq;
	} sdc_pins_t;

	typedef struct packed {
		logic [MASK_W-1:0] mask;
		logic [BANK_W-1:0] bank;
		logic [MEM_COL_W-1:0] col;
		logic [DATA_W-1:0] data;
	} sdc_wr_t;

	// chip select high forces the deselect code whatever the strobes say
	function automatic sdc_cmd_t sdc_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		sdc_cmd_t c;
		c = CMD_OTHER;
		if (cs_n) begin
			c = CMD_DESEL;
		end else begin
			case ({ras_n, cas_n, we_n})
				3'b111: c = CMD_NOP;
				3'b011: c = CMD_OPEN;
				3'b010: c = CMD_CLOSE;
				3'b101: c = CMD_READ;
				3'b100: c = CMD_WRITE;
				default: c = CMD_OTHER;
			endcase
		end
		return c;
	endfunction
endpackage

//--- sdc_fifo_if.sv
/*
 * Valid/ready carrier between the decoder and its write buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface sdc_fifo_if #(parameter int W = 8);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface

//--- sdc_fifo.sv
/*
 * Synchronous FIFO with parameter width and power-of-two depth.
 * Assumes one clock, a synchronous reset and a freezing clock enable.
 */
`timescale 1ns/100ps
module sdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // clock
	input wire logic rst, // synchronous reset
	input wire logic ce, // clock enable
	sdc_fifo_if.fifo port // both sides
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("sdc_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire push = port.in_valid && !full;
	wire pop = !empty && port.out_ready;

	assign port.in_ready = !full;
	assign port.out_valid = !empty;
	assign port.out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (ce) begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && push) mem[wr_ptr[AW-1:0]] <= port.in_data;
	end
endmodule // sdc_fifo

//--- sdc_ctrl_model.sv
/*
 * Behavioural stand-in for the external memory controller on the command and data pins.
 * Assumes the bench hands it one pin set per cycle, changed just after rising clk.
 */
`timescale 1ns/100ps
module sdc_ctrl_model
	import sdc_pkg::*;
(
	input wire logic clk, // system clock
	input wire sdc_pkg::sdc_pins_t req, // pin values asked for this cycle
	input wire logic drive, // controller drives the data lines
	output sdc_pkg::sdc_pins_t pins // pins as seen by the device
);
	logic [DATA_W-1:0] last = '0;

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// select and strobes held from one edge to the next as one command code
	assign pins.cs_n = req.cs_n;
	assign pins.ras_n = req.ras_n;
	assign pins.cas_n = req.cas_n;
	assign pins.we_n = req.we_n;
	assign pins.ba = req.ba;
	assign pins.addr = req.addr;
	assign pins.lower_byte_mask = req.lower_byte_mask;
	assign pins.upper_byte_mask = req.upper_byte_mask;
	// released lines show the inverse of the last word, never a stale copy
	assign pins.dq = drive ? req.dq : ~last;

	always @(posedge clk) begin
		if (drive) begin
			last <= req.dq;
		end
	end
endmodule // sdc_ctrl_model

//--- sdram_command_pin_decode_tb.sv
/*
 * Self-checking bench for the command-pin decoder, with a word-array model.
 * Assumes the controller model on the pins and the hand-over pipeline latency.
 */
`timescale 1ns/100ps
module sdram_command_pin_decode_tb;
	import sdc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic drive = 1'b0;
	logic ce = 1'b1;
	sdc_pins_t req = '1;
	sdc_pins_t pins;
	logic [15:0] d_out;
	logic [1:0] oe;
	logic [3:0] bact;
	logic wr_rdy;
	logic [15:0] mem [64];
	logic [31:0] seed = 32'h0000001e;
	logic [31:0] r;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;

	// ----------------------------------------------------------------
	// clock, parts
	// ----------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	sdc_ctrl_model u_sdc_ctrl_model (.clk(clk), .req(req), .drive(drive), .pins(pins));

	sdc_decoder u_sdc_decoder (.CLOCK(clk), .RST(rst), .CE(ce), .CS_N(pins.cs_n),
		.ROW_STROBE_N(pins.ras_n), .COL_STROBE_N(pins.cas_n), .WRITE_SELECT_N(pins.we_n),
		.BANK_SELECT(pins.ba), .ADDR(pins.addr), .LOWER_BYTE_MASK(pins.lower_byte_mask),
		.UPPER_BYTE_MASK(pins.upper_byte_mask), .DATA_LINES_IN(pins.dq), .DATA_LINES_OUT(d_out),
		.DATA_LINES_OE(oe), .BANK_ACTIVE(bact), .WR_READY(wr_rdy));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task print_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e, input string what);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask

	task chk_data(input logic [15:0] g, input logic [15:0] e);
		chk(g, e, "read word");
	endtask

	task chk_oe(input logic [1:0] g, input logic [1:0] e);
		chk({14'h0, g}, {14'h0, e}, "drive enable");
	endtask

	task chk_bank(input logic [3:0] g, input logic [3:0] e);
		chk({12'h0, g}, {12'h0, e}, "bank state");
	endtask

	// c = {select, row, column, write}; deselect follows one cycle later
	task issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
		input logic [1:0] m, input logic [15:0] d, input logic w);
		@(posedge clk);
		req <= '{cs_n:c[3], ras_n:c[2], cas_n:c[1], we_n:c[0], ba:b, addr:a,
			lower_byte_mask:m[0], upper_byte_mask:m[1], dq:d};
		drive <= w;
		@(posedge clk);
		req <= '1;
		drive <= 1'b0;
	endtask

	task bk(input logic [3:0] e);
		repeat (4) @(posedge clk);
		#1;
		chk_bank(bact, e);
	endtask

	task wr(input logic [1:0] b, input logic [3:0] col, input logic [1:0] m,
		input logic [15:0] d);
		issue(4'b0100, b, {9'h0, col}, m, d, 1'b1);
		if (!m[0]) mem[{b, col}][7:0] = d[7:0];
		if (!m[1]) mem[{b, col}][15:8] = d[15:8];
	endtask

	task rd(input logic [1:0] b, input logic [3:0] col, input logic [1:0] m,
		input logic sel_n, input logic en, input logic ac);
		logic [15:0] k;
		k = {{8{~m[1]}}, {8{~m[0]}}};
		issue({sel_n, 3'b101}, b, {2'b00, ac, 6'h0, col}, m, 16'h0, 1'b0);
		// the answer stands for one cycle, two edges after the pins were taken
		repeat (2) @(posedge clk);
		#1;
		chk_oe(oe, en ? ~m : 2'b00);
		if (en) chk_data(d_out & k, mem[{b, col}] & k);
		@(posedge clk);
		#1;
		chk_oe(oe, 2'b00);
	endtask

	// ----------------------------------------------------------------
	// run
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_bank(bact, 4'h0);
		chk({15'h0, wr_rdy}, 16'h0001, "buffer room");
		for (int i = 0; i < 4; i++) issue(4'b0011, i[1:0], 13'h1abc, 2'b11, 16'h0, 1'b0);
		bk(4'hf);
		issue(4'b1010, 2'd0, 13'h0400, 2'b00, 16'h0, 1'b0);
		issue(4'b0111, 2'd1, 13'h0400, 2'b00, 16'h0, 1'b0);
		bk(4'hf);
		issue(4'b0110, 2'd2, 13'h0400, 2'b00, 16'h0, 1'b0);
		issue(4'b0000, 2'd3, 13'h0400, 2'b00, 16'h0, 1'b0);
		issue(4'b0011, 2'd0, 13'h0123, 2'b00, 16'h0, 1'b0);
		bk(4'hf);
		// a close-all presented while frozen must be lost entirely
		@(posedge clk);
		ce <= 1'b0;
		issue(4'b0010, 2'd0, 13'h0400, 2'b00, 16'h0, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		bk(4'hf);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			wr(i[1:0], i[3:0], 2'b00, r[15:0]);
		end
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			wr(i[1:0], i[3:0], r[17:16], r[15:0]);
		end
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			rd(i[1:0], i[3:0], r[1:0], 1'b0, 1'b1, 1'b0);
		end
		rd(2'd0, 4'd0, 2'b00, 1'b1, 1'b0, 1'b0);
		issue(4'b0010, 2'd1, 13'h0000, 2'b00, 16'h0, 1'b0);
		bk(4'hd);
		rd(2'd1, 4'd1, 2'b00, 1'b0, 1'b0, 1'b0);
		rd(2'd3, 4'd3, 2'b00, 1'b0, 1'b1, 1'b1);
		bk(4'h5);
		issue(4'b0010, 2'd0, 13'h0400, 2'b00, 16'h0, 1'b0);
		bk(4'h0);
		issue(4'b0011, 2'd2, 13'h0005, 2'b00, 16'h0, 1'b0);
		bk(4'h4);
		print_verdict();
	end
endmodule // sdram_command_pin_decode_tb
